// ### include/ppg_pkg.sv
package ppg_pkg;

  localparam int unsigned NUM_CH = 32;

  // register byte offsets
  localparam logic [11:0] ADDR_CTRL   = 12'h000;
  localparam logic [11:0] ADDR_ERR    = 12'h004;
  localparam logic [11:0] ADDR_BLOCK  = 12'h008;
  localparam logic [11:0] ADDR_BURST  = 12'h00C;
  localparam logic [11:0] ADDR_STATUS = 12'h010;

  // control register fields
  localparam int unsigned C_PRE_EN   = 0;
  localparam int unsigned C_PRE_INIT = 1;
  localparam int unsigned C_BURST    = 2;
  localparam int unsigned C_MIXED    = 3;
  localparam int unsigned C_SEQPAT   = 4;
  localparam int unsigned C_AREA_BLK = 5;
  localparam int unsigned C_ERR_EN   = 6;
  localparam int unsigned C_BSRC_LO  = 7;
  localparam logic [31:0] CTRL_MASK  = 32'h0000_01FF;

  // error configuration fields
  localparam int unsigned E_SRC_LO   = 0;
  localparam int unsigned E_SINGLE   = 2;
  localparam int unsigned E_SCAN     = 3;
  localparam int unsigned E_CH_LO    = 4;
  localparam int unsigned E_MANT_LO  = 9;
  localparam int unsigned E_EXP_LO   = 13;
  localparam int unsigned E_XBURST   = 17;
  localparam int unsigned E_BLEN_LO  = 18;
  localparam logic [31:0] ERR_MASK   = 32'h01FF_FFFF;

  // burst window fields (units: stream words)
  localparam int unsigned B_CYCLE_LO = 0;
  localparam int unsigned B_EN_LO    = 16;

  // status fields
  localparam int unsigned S_PRE_ACT  = 0;
  localparam int unsigned S_EXT_OK   = 1;
  localparam int unsigned S_AREA_ACT = 2;
  localparam int unsigned S_DONE     = 3;
  localparam int unsigned S_OPEN     = 4;
  localparam int unsigned S_CNT_LO   = 16;

  // reset values
  localparam logic [31:0] CTRL_RST   = 32'h0000_0000;
  localparam logic [31:0] ERR_RST    = 32'h0005_8200;
  localparam logic [7:0]  BLOCK_RST  = 8'h00;
  localparam logic [31:0] BURST_RST  = 32'h0032_0064;

  // ratio and burst limits
  localparam logic [3:0]  MANT_MIN   = 4'h1;
  localparam logic [3:0]  MANT_MAX   = 4'h9;
  localparam logic [3:0]  MANT_CAP   = 4'h5;
  localparam logic [3:0]  EXP_MIN    = 4'h3;
  localparam logic [3:0]  EXP_MAX    = 4'hC;
  localparam logic [6:0]  BLEN_MIN   = 7'h01;

  typedef enum logic [1:0] {
    SRC_INTERNAL    = 2'b00,
    SRC_EXT_TRIG    = 2'b01,
    SRC_EXT_DISABLE = 2'b10
  } err_src_t;

  typedef enum logic [1:0] {
    BSRC_INTERNAL = 2'b00,
    BSRC_EXT_TRIG = 2'b01,
    BSRC_EXT_EN   = 2'b10
  } burst_src_t;

endpackage

// ### include/stream_if.sv
`timescale 1ns/1ps
`default_nettype none
interface stream_if;
  logic        valid;
  logic        ready;
  logic [31:0] data;
  logic [7:0]  block;
  modport sink   (input valid, input data, input block, output ready);
  modport source (output valid, output data, output block, input ready);
endinterface
`default_nettype wire

// ### design/word_buffer.sv
`timescale 1ns/1ps
`default_nettype none
module word_buffer (
  input  wire logic clock,
  input  wire logic rst_n,
  stream_if.sink    up,
  stream_if.source  dn
);
  logic [39:0] mem_q [2];
  logic        wr_ptr_q;
  logic        rd_ptr_q;
  logic [1:0]  cnt_q;
  logic [1:0]  cnt_d;
  logic        full_q;
  logic        push;
  logic        pop;

  // ready comes from a flop so the upstream path stays short
  assign up.ready = !full_q;
  assign push     = up.valid && !full_q;
  assign dn.valid = (cnt_q != 2'h0);
  assign pop      = dn.valid && dn.ready;
  assign dn.data  = mem_q[rd_ptr_q][31:0];
  assign dn.block = mem_q[rd_ptr_q][39:32];
  assign cnt_d    = cnt_q + {1'b0, push} - {1'b0, pop};

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      wr_ptr_q <= 1'b0;
      rd_ptr_q <= 1'b0;
      cnt_q    <= 2'h0;
      full_q   <= 1'b0;
    end else begin
      if (push) begin
        wr_ptr_q <= !wr_ptr_q;
      end
      if (pop) begin
        rd_ptr_q <= !rd_ptr_q;
      end
      cnt_q  <= cnt_d;
      full_q <= (cnt_d == 2'h2);
    end
  end

  always_ff @(posedge clock) begin
    if (push) begin
      mem_q[wr_ptr_q] <= {up.block, up.data};
    end
  end
endmodule
`default_nettype wire

// ### design/precode_error_inserter.sv
// What this block does
// - a switchable differential precoder for the two-channel DQPSK pair starts from a selectable data value of 0 or 1.
// - the precoder can be active only in continuous repeat mode and never in burst mode.
// - errors go into the whole pattern or one chosen block, and the block choice works only for mixed patterns.
// - internal insertion is repeated or single at a ratio of 1..9 times ten to minus 3..12, capped at 5E-3.
// - internal errors go to one of 32 channels or scan across channels, selection applying to internal only.
// - external trigger inserts an error on each rising edge, and in disable mode a low input suppresses insertion.
// - external insertion is a single-bit error or a burst of 1 to 127.
// - external insertion is allowed only when the test pattern is not a sequence pattern.
// - repeat sequence mode outputs continuously, burst mode gates the output from an internal or external source.
//
// The APB interface to the registers and the register addresses were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module precode_error_inserter (
  input  wire logic        clock,
  input  wire logic        rst_n,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output var  logic [31:0] prdata,
  output var  logic        pready,
  output var  logic        pslverr,
  input  wire logic        in_valid,
  output var  logic        in_ready,
  input  wire logic [31:0] in_data,
  input  wire logic [7:0]  in_block,
  output var  logic        out_valid,
  input  wire logic        out_ready,
  output var  logic [31:0] out_data,
  input  wire logic        err_trig,
  input  wire logic        burst_aux
);
  stream_if buf_in ();
  stream_if buf_out ();

  logic [31:0] ctrl_q;
  logic [31:0] errcfg_q;
  logic [7:0]  block_q;
  logic [31:0] burst_q;
  logic [31:0] prdata_q;
  logic        pready_q;
  logic        pslverr_q;
  logic [31:0] out_data_q;
  logic        out_valid_q;
  logic [1:0]  prev_q;
  logic [39:0] acc_q;
  logic [4:0]  chan_q;
  logic        single_done_q;
  logic [6:0]  xb_cnt_q;
  logic        trig_prev_q;
  logic        aux_prev_q;
  logic [15:0] bcnt_q;
  logic        brun_q;
  logic [15:0] err_cnt_q;

  assign buf_in.valid  = in_valid;
  assign buf_in.data   = in_data;
  assign buf_in.block  = in_block;
  assign in_ready      = buf_in.ready;

  word_buffer u_buf (
    .clock (clock),
    .rst_n (rst_n),
    .up    (buf_in),
    .dn    (buf_out)
  );

  function automatic logic [31:0] clean_err(input logic [31:0] w);
    logic [3:0]  m;
    logic [3:0]  e;
    logic [6:0]  b;
    logic [31:0] r;
    r = w & ppg_pkg::ERR_MASK;
    m = w[ppg_pkg::E_MANT_LO +: 4];
    e = w[ppg_pkg::E_EXP_LO +: 4];
    b = w[ppg_pkg::E_BLEN_LO +: 7];
    if (e < ppg_pkg::EXP_MIN) e = ppg_pkg::EXP_MIN;
    if (e > ppg_pkg::EXP_MAX) e = ppg_pkg::EXP_MAX;
    if (m < ppg_pkg::MANT_MIN) m = ppg_pkg::MANT_MIN;
    if (m > ppg_pkg::MANT_MAX) m = ppg_pkg::MANT_MAX;
    if (e == ppg_pkg::EXP_MIN && m > ppg_pkg::MANT_CAP) m = ppg_pkg::MANT_CAP;
    if (b < ppg_pkg::BLEN_MIN) b = ppg_pkg::BLEN_MIN;
    r[ppg_pkg::E_MANT_LO +: 4] = m;
    r[ppg_pkg::E_EXP_LO +: 4]  = e;
    r[ppg_pkg::E_BLEN_LO +: 7] = b;
    return r;
  endfunction

  function automatic logic [39:0] pow10(input logic [3:0] n);
    case (n)
      4'h4:    pow10 = 40'h00_0000_2710;
      4'h5:    pow10 = 40'h00_0001_86A0;
      4'h6:    pow10 = 40'h00_000F_4240;
      4'h7:    pow10 = 40'h00_0098_9680;
      4'h8:    pow10 = 40'h00_05F5_E100;
      4'h9:    pow10 = 40'h00_3B9A_CA00;
      4'hA:    pow10 = 40'h02_540B_E400;
      4'hB:    pow10 = 40'h17_4876_E800;
      4'hC:    pow10 = 40'hE8_D4A5_1000;
      default: pow10 = 40'h00_0000_03E8;
    endcase
  endfunction

  // gray-mapped quadrant index of an (I,Q) bit pair and back
  function automatic logic [1:0] to_phase(input logic [1:0] b);
    to_phase = {b[1], b[1] ^ b[0]};
  endfunction

  function automatic logic [1:0] to_bits(input logic [1:0] p);
    to_bits = {p[1], p[1] ^ p[0]};
  endfunction

  // register bus decode
  wire setup    = psel && !penable;
  wire wr_en    = psel && penable && pready_q && pwrite;
  wire sel_ctrl = (paddr == ppg_pkg::ADDR_CTRL);
  wire sel_err  = (paddr == ppg_pkg::ADDR_ERR);
  wire sel_blk  = (paddr == ppg_pkg::ADDR_BLOCK);
  wire sel_bst  = (paddr == ppg_pkg::ADDR_BURST);
  wire sel_stat = (paddr == ppg_pkg::ADDR_STATUS);
  wire mapped   = sel_ctrl || sel_err || sel_blk || sel_bst || sel_stat;
  wire wr_err   = wr_en && sel_err;

  // configuration fields
  wire                   err_en    = ctrl_q[ppg_pkg::C_ERR_EN];
  wire                   mixed     = ctrl_q[ppg_pkg::C_MIXED];
  wire                   burst_md  = ctrl_q[ppg_pkg::C_BURST];
  wire                   single    = errcfg_q[ppg_pkg::E_SINGLE];
  wire                   scan      = errcfg_q[ppg_pkg::E_SCAN];
  wire                   xburst    = errcfg_q[ppg_pkg::E_XBURST];
  wire [3:0]             mant      = errcfg_q[ppg_pkg::E_MANT_LO +: 4];
  wire [3:0]             expo      = errcfg_q[ppg_pkg::E_EXP_LO +: 4];
  wire [6:0]             blen      = errcfg_q[ppg_pkg::E_BLEN_LO +: 7];
  wire [15:0]            b_cycle   = burst_q[ppg_pkg::B_CYCLE_LO +: 16];
  wire [15:0]            b_enable  = burst_q[ppg_pkg::B_EN_LO +: 16];
  ppg_pkg::err_src_t     src;
  ppg_pkg::burst_src_t   bsrc;
  assign src  = ppg_pkg::err_src_t'(errcfg_q[ppg_pkg::E_SRC_LO +: 2]);
  assign bsrc = ppg_pkg::burst_src_t'(ctrl_q[ppg_pkg::C_BSRC_LO +: 2]);

  wire pre_active  = ctrl_q[ppg_pkg::C_PRE_EN] && !burst_md;
  wire ext_ok      = !ctrl_q[ppg_pkg::C_SEQPAT];
  wire area_active = ctrl_q[ppg_pkg::C_AREA_BLK] && mixed;
  wire area_hit    = !area_active || (buf_out.block == block_q);

  wire fire        = buf_out.valid && (out_ready || !out_valid_q);
  assign buf_out.ready = out_ready || !out_valid_q;

  // precoder on channel pair 0/1
  wire [1:0] ph_out   = to_phase(buf_out.data[1:0]) + prev_q;
  // a control write that switches the precoder on also brings its start value
  wire       init_sel = (wr_en && sel_ctrl) ? pwdata[ppg_pkg::C_PRE_INIT] : ctrl_q[ppg_pkg::C_PRE_INIT];
  wire [1:0] ph_init  = init_sel ? to_phase(2'b11) : to_phase(2'b00);
  wire [31:0] precoded = pre_active ? {buf_out.data[31:2], to_bits(ph_out)} : buf_out.data;

  // ratio generator: one hit per 10^n/m words
  wire [39:0] period   = pow10(expo);
  wire [40:0] acc_sum  = {1'b0, acc_q} + {37'h0, mant};
  wire        ratio_hit = (acc_sum >= {1'b0, period});
  wire [39:0] acc_next = ratio_hit ? 40'(acc_sum - {1'b0, period}) : acc_sum[39:0];
  wire        int_hit  = ratio_hit && !(single && single_done_q);
  wire        trig_rise = err_trig && !trig_prev_q;
  wire        aux_rise  = burst_aux && !aux_prev_q;
  wire        ratio_run = (src == ppg_pkg::SRC_INTERNAL) || (src == ppg_pkg::SRC_EXT_DISABLE);

  // burst window
  logic burst_open;
  always_comb begin
    case (bsrc)
      ppg_pkg::BSRC_INTERNAL: burst_open = (bcnt_q < b_enable);
      ppg_pkg::BSRC_EXT_TRIG: burst_open = brun_q;
      ppg_pkg::BSRC_EXT_EN:   burst_open = burst_aux;
      default:                burst_open = 1'b0;
    endcase
    if (!burst_md) burst_open = 1'b1;
  end

  // error mask, one bit per channel
  logic [31:0] raw_mask;
  always_comb begin
    case (src)
      ppg_pkg::SRC_INTERNAL:    raw_mask = int_hit ? (32'h0000_0001 << chan_q) : 32'h0;
      ppg_pkg::SRC_EXT_TRIG:    raw_mask = (ext_ok && xb_cnt_q != 7'h0) ? 32'hFFFF_FFFF : 32'h0;
      ppg_pkg::SRC_EXT_DISABLE: raw_mask = (ext_ok && err_trig && int_hit) ? 32'hFFFF_FFFF : 32'h0;
      default:                  raw_mask = 32'h0;
    endcase
  end
  wire [31:0] mask     = (err_en && area_hit && burst_open) ? raw_mask : 32'h0;
  wire        inserted = fire && (mask != 32'h0);

  wire [31:0] status = {err_cnt_q, 11'h0, burst_open, single_done_q, area_active, ext_ok, pre_active};
  wire [31:0] rd_mux = sel_ctrl ? ctrl_q :
                       sel_err  ? errcfg_q :
                       sel_blk  ? {24'h0, block_q} :
                       sel_bst  ? burst_q :
                       sel_stat ? status : 32'h0;

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q  <= 32'h0;
    end else begin
      pready_q  <= setup && !pready_q;
      pslverr_q <= setup && !mapped;
      prdata_q  <= setup ? rd_mux : 32'h0;
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      ctrl_q   <= ppg_pkg::CTRL_RST;
      errcfg_q <= ppg_pkg::ERR_RST;
      block_q  <= ppg_pkg::BLOCK_RST;
      burst_q  <= ppg_pkg::BURST_RST;
    end else if (wr_en) begin
      if (sel_ctrl) ctrl_q <= pwdata & ppg_pkg::CTRL_MASK;
      if (sel_err)  errcfg_q <= clean_err(pwdata);
      if (sel_blk)  block_q <= pwdata[7:0];
      if (sel_bst)  burst_q <= pwdata;
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      acc_q         <= 40'h0;
      single_done_q <= 1'b0;
      chan_q        <= 5'h0;
    end else begin
      if (wr_err) begin
        acc_q  <= 40'h0;
        chan_q <= pwdata[ppg_pkg::E_CH_LO +: 5];
      end else begin
        if (fire && ratio_run) acc_q <= acc_next;
        if (inserted && src == ppg_pkg::SRC_INTERNAL && scan) chan_q <= chan_q + 5'h1;
      end
      // a hit in the same cycle as the re-arm write still counts
      if (inserted && single && src == ppg_pkg::SRC_INTERNAL) single_done_q <= 1'b1;
      else if (wr_err) single_done_q <= 1'b0;
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      trig_prev_q <= 1'b0;
      aux_prev_q  <= 1'b0;
      xb_cnt_q    <= 7'h0;
    end else begin
      trig_prev_q <= err_trig;
      aux_prev_q  <= burst_aux;
      if (trig_rise && ext_ok && err_en && src == ppg_pkg::SRC_EXT_TRIG) begin
        xb_cnt_q <= xburst ? blen : 7'h01;
      end else if (fire && xb_cnt_q != 7'h0) begin
        xb_cnt_q <= xb_cnt_q - 7'h1;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      bcnt_q <= 16'h0;
      brun_q <= 1'b0;
    end else if (bsrc == ppg_pkg::BSRC_EXT_TRIG) begin
      if (aux_rise) begin
        bcnt_q <= 16'h0;
        brun_q <= 1'b1;
      end else if (fire && brun_q) begin
        bcnt_q <= bcnt_q + 16'h1;
        brun_q <= (bcnt_q + 16'h1 < b_enable);
      end
    end else if (fire) begin
      bcnt_q <= (bcnt_q + 16'h1 >= b_cycle) ? 16'h0 : bcnt_q + 16'h1;
      brun_q <= 1'b0;
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      prev_q      <= 2'h0;
      out_valid_q <= 1'b0;
      out_data_q  <= 32'h0;
      err_cnt_q   <= 16'h0;
    end else begin
      if (!pre_active) prev_q <= ph_init;
      else if (fire) prev_q <= ph_out;
      if (fire) begin
        out_valid_q <= 1'b1;
        out_data_q  <= burst_open ? (precoded ^ mask) : 32'h0;
      end else if (out_ready) begin
        out_valid_q <= 1'b0;
      end
      if (inserted) err_cnt_q <= err_cnt_q + 16'h1;
    end
  end

  assign prdata    = prdata_q;
  assign pready    = pready_q;
  assign pslverr   = pslverr_q;
  assign out_valid = out_valid_q;
  assign out_data  = out_data_q;

  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);

  AST_PRECODE_START: assert property (
    !pre_active |=> prev_q == (ctrl_q[ppg_pkg::C_PRE_INIT] ? 2'b10 : 2'b00))
    else $error("precoder start value wrong");
  AST_NO_PRECODE_IN_BURST: assert property (
    fire && burst_md && burst_open && mask == 32'h0 |=> out_data_q == $past(buf_out.data))
    else $error("precoder active in burst mode");
  AST_BLOCK_AREA: assert property (
    fire && area_active && buf_out.block != block_q |=> err_cnt_q == $past(err_cnt_q))
    else $error("error inserted outside chosen block");
  AST_RATIO_CAP: assert property (
    expo >= 4'h3 && expo <= 4'hC && mant >= 4'h1 && mant <= 4'h9 && (expo != 4'h3 || mant <= 4'h5))
    else $error("error ratio out of range");
  AST_SINGLE_ONCE: assert property (
    single_done_q && single && src == ppg_pkg::SRC_INTERNAL && !wr_err |-> mask == 32'h0)
    else $error("single error repeated");
  AST_SCAN_STEP: assert property (
    inserted && src == ppg_pkg::SRC_INTERNAL && scan && !wr_err |=> chan_q == $past(chan_q) + 5'h1)
    else $error("channel scan did not advance");
  AST_DISABLE_LOW: assert property (
    fire && src == ppg_pkg::SRC_EXT_DISABLE && !err_trig |=> err_cnt_q == $past(err_cnt_q))
    else $error("error inserted while disabled");
  AST_BURST_LEN: assert property (
    trig_rise && ext_ok && err_en && src == ppg_pkg::SRC_EXT_TRIG
      |=> xb_cnt_q == ($past(xburst) ? $past(blen) : 7'h01))
    else $error("external burst length wrong");
  AST_EXT_BLOCKED: assert property (
    !ext_ok && src != ppg_pkg::SRC_INTERNAL |-> mask == 32'h0)
    else $error("external error with sequence pattern");
  AST_BURST_GATE: assert property (
    fire && burst_md && bsrc == ppg_pkg::BSRC_EXT_EN && !burst_aux |=> out_data_q == 32'h0)
    else $error("output not gated outside burst window");
  AST_ONE_BIT_FLIP: assert property (
    fire && burst_open && src == ppg_pkg::SRC_INTERNAL
      |=> $countones(out_data_q ^ $past(precoded)) <= 1)
    else $error("more than one bit inverted");
endmodule
`default_nettype wire

// ### dv/sink_model.sv
`timescale 1ns/1ps
`default_nettype none
module sink_model (
  input  wire logic        clock,
  input  wire logic        rst_n,
  input  wire logic        out_valid,
  input  wire logic [31:0] out_data,
  input  wire logic        stall,
  output var  logic        out_ready
);
  logic [31:0] got_q[$];
  logic [1:0]  phase_q = 2'h0;
  // while stalling the sink only takes words two cycles out of four
  assign out_ready = !stall || phase_q[1];
  always @(posedge clock) begin
    if (out_valid === 1'b1 && out_ready) begin
      got_q.push_back(out_data);
    end
    phase_q <= rst_n ? phase_q + 2'h1 : 2'h0;
  end
endmodule
`default_nettype wire

// ### dv/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic        clock;
  logic        rst_n;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        in_valid;
  logic        in_ready;
  logic [31:0] in_data;
  logic        out_valid;
  logic        out_ready;
  logic [31:0] out_data;
  logic        err_trig;
  logic [7:0]  in_block;
  logic        burst_aux;
  logic        pre_on;
  logic        zero_on;
  logic [1:0]  pre_ph;
  logic        stall;
  logic        saw_full;
  logic        err_q;
  logic [31:0] rd;
  logic [31:0] sent_q[$];
  int          num_errors;
  int          n_compared;
  // control value, status bit, expected level
  localparam logic [11:0] STAT_TAB [6] = '{
    {9'h001, 2'h0, 1'h1}, {9'h005, 2'h0, 1'h0}, {9'h020, 2'h2, 1'h0},
    {9'h028, 2'h2, 1'h1}, {9'h040, 2'h1, 1'h1}, {9'h050, 2'h1, 1'h0}};

  precode_error_inserter u_dut (.clock(clock), .rst_n(rst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .in_valid(in_valid), .in_ready(in_ready), .in_data(in_data),
    .in_block(in_block), .out_valid(out_valid), .out_ready(out_ready), .out_data(out_data),
    .err_trig(err_trig), .burst_aux(burst_aux));

  sink_model u_sink (.clock(clock), .rst_n(rst_n), .out_valid(out_valid), .out_data(out_data),
    .stall(stall), .out_ready(out_ready));

  task automatic close_out;
    $display("compared %0d mismatches %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task automatic check32(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      num_errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clock);
    penable <= 1'b1;
    do begin
      @(posedge clock);
    end while (pready !== 1'b1);
    rd = prdata;
    err_q = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge clock);
  endtask

  // sends n words back to back, pulses the trigger at word trig_at, counts altered words
  task automatic run_stream(input int n, input int trig_at, input int exp_diff, input logic [31:0] mask);
    int          k;
    int          w;
    int          diffs;
    logic [31:0] d;
    logic [1:0]  ph;
    diffs = 0;
    sent_q = {};
    u_sink.got_q = {};
    for (k = 0; k < n; k++) begin
      d = 32'h5A3C_0000 ^ (32'h0001_0F01 * 32'(k));
      in_valid <= 1'b1;
      in_data  <= d;
      err_trig <= (k >= trig_at) && (k < trig_at + 2);
      sent_q.push_back(d);
      @(posedge clock);
      while (in_ready !== 1'b1) begin
        saw_full = 1'b1;
        @(posedge clock);
      end
    end
    in_valid <= 1'b0;
    err_trig <= 1'b0;
    w = 0;
    while (u_sink.got_q.size() < n && w < 3000) begin
      @(posedge clock);
      w++;
    end
    check32(32'(u_sink.got_q.size()), 32'(n));
    ph = pre_ph;
    for (k = 0; k < n && k < u_sink.got_q.size(); k++) begin
      d = zero_on ? 32'h0 : sent_q[k];
      // differential gray quadrant coding of the pair in bits 1:0
      if (pre_on) begin
        ph = ph + {d[1], d[1] ^ d[0]};
        d[1:0] = {ph[1], ph[1] ^ ph[0]};
      end
      if (u_sink.got_q[k] !== d) begin
        diffs++;
        check32(u_sink.got_q[k] ^ d, mask);
      end
    end
    check32(32'(diffs), 32'(exp_diff));
  endtask

  task automatic t_regs;
    apb(1'b0, ppg_pkg::ADDR_CTRL, 32'h0);
    check32(rd, ppg_pkg::CTRL_RST);
    apb(1'b0, ppg_pkg::ADDR_ERR, 32'h0);
    check32(rd, ppg_pkg::ERR_RST);
    apb(1'b0, ppg_pkg::ADDR_BURST, 32'h0);
    check32(rd, ppg_pkg::BURST_RST);
    apb(1'b0, 12'h020, 32'h0);
    check32({rd[30:0], err_q}, 32'h0000_0001);
    apb(1'b1, ppg_pkg::ADDR_ERR, 32'h0000_7200);
    apb(1'b0, ppg_pkg::ADDR_ERR, 32'h0);
    check32(rd, 32'h0004_6A00);
  endtask

  task automatic t_status;
    int i;
    for (i = 0; i < 6; i++) begin
      apb(1'b1, ppg_pkg::ADDR_CTRL, {23'h0, STAT_TAB[i][11:3]});
      apb(1'b0, ppg_pkg::ADDR_STATUS, 32'h0);
      check32({31'h0, rd[STAT_TAB[i][2:1]]}, {31'h0, STAT_TAB[i][0]});
    end
  endtask

  task automatic t_pass;
    saw_full = 1'b0;
    apb(1'b1, ppg_pkg::ADDR_CTRL, 32'h0);
    run_stream(24, 999, 0, 32'h0);
    check32({31'h0, saw_full}, 32'h0000_0001);
  endtask

  task automatic t_precode;
    pre_on = 1'b1;
    pre_ph = 2'b10;
    apb(1'b1, ppg_pkg::ADDR_CTRL, 32'h0000_0003);
    run_stream(8, 999, 0, 32'h0);
    apb(1'b1, ppg_pkg::ADDR_CTRL, 32'h0);
    pre_ph = 2'b00;
    apb(1'b1, ppg_pkg::ADDR_CTRL, 32'h0000_0001);
    run_stream(8, 999, 0, 32'h0);
    pre_on = 1'b0;
    burst_aux <= 1'b1;
    apb(1'b1, ppg_pkg::ADDR_CTRL, 32'h0000_0107);
    run_stream(8, 999, 0, 32'h0);
    burst_aux <= 1'b0;
    zero_on = 1'b1;
    run_stream(8, 999, 0, 32'h0);
    zero_on = 1'b0;
  endtask

  task automatic t_area;
    apb(1'b1, ppg_pkg::ADDR_BLOCK, 32'h0000_0001);
    apb(1'b1, ppg_pkg::ADDR_CTRL, 32'h0000_0068);
    apb(1'b1, ppg_pkg::ADDR_ERR, 32'h0005_8201);
    in_block <= 8'h00;
    run_stream(16, 4, 0, 32'h0);
    in_block <= 8'h01;
    run_stream(16, 4, 1, 32'hFFFF_FFFF);
    in_block <= 8'h00;
  endtask

  task automatic t_ext;
    apb(1'b1, ppg_pkg::ADDR_CTRL, 32'h0000_0040);
    apb(1'b1, ppg_pkg::ADDR_ERR, 32'h0005_8201);
    run_stream(16, 4, 1, 32'hFFFF_FFFF);
    apb(1'b1, ppg_pkg::ADDR_ERR, 32'h000F_8201);
    run_stream(16, 4, 3, 32'hFFFF_FFFF);
    apb(1'b1, ppg_pkg::ADDR_CTRL, 32'h0000_0050);
    apb(1'b1, ppg_pkg::ADDR_ERR, 32'h0005_8201);
    run_stream(16, 4, 0, 32'h0);
  endtask

  task automatic t_int;
    stall <= 1'b0;
    apb(1'b1, ppg_pkg::ADDR_CTRL, 32'h0000_0040);
    apb(1'b1, ppg_pkg::ADDR_ERR, 32'h0000_6A00);
    run_stream(300, 999, 1, 32'h0000_0001);
    apb(1'b1, ppg_pkg::ADDR_ERR, 32'h0000_6BF0);
    run_stream(300, 999, 1, 32'h8000_0000);
    apb(1'b1, ppg_pkg::ADDR_ERR, 32'h0000_6A0C);
    run_stream(500, 999, 1, 32'h0000_0001);
    apb(1'b1, ppg_pkg::ADDR_ERR, 32'h0000_6A02);
    run_stream(300, 999, 0, 32'h0);
  endtask

  initial begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end

  initial begin
    repeat (20000) @(posedge clock);
    num_errors++;
    close_out;
  end

  initial begin
    num_errors = 0;
    n_compared = 0;
    rst_n = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    in_valid = 1'b0;
    in_data = 32'h0;
    err_trig = 1'b0;
    in_block = 8'h00;
    burst_aux = 1'b0;
    pre_on = 1'b0;
    zero_on = 1'b0;
    pre_ph = 2'b00;
    stall = 1'b1;
    repeat (12) @(posedge clock);
    rst_n <= 1'b1;
    @(posedge clock);
    t_regs;
    t_status;
    t_pass;
    t_precode;
    t_ext;
    t_area;
    t_int;
    close_out;
  end
endmodule
`default_nettype wire
